//--- ccd_defs.svh
// Offsets, field positions, reset values and timing counts of the current datapath.
// Assumes inclusion by ccd_pkg.sv and ccd_top.sv; holds definitions only.
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

`define CCD_ADDR_W        8
`define CCD_OFS_GAIN_A    8'h00
`define CCD_OFS_GAIN_B    8'h01
`define CCD_OFS_GAIN_C    8'h02
`define CCD_OFS_GAIN_N    8'h03
`define CCD_OFS_HPF_DIS   8'h04
`define CCD_OFS_WAVE_A    8'h08
`define CCD_OFS_WAVE_B    8'h09
`define CCD_OFS_WAVE_C    8'h0a
`define CCD_OFS_WAVE_N    8'h0b
`define CCD_OFS_FIRST_STATUS_REGISTER   8'h0c
`define CCD_OFS_FIRST_INTERRUPT_MASK     8'h0d
`define CCD_RDY_BIT       17
`define CCD_GAIN_RST      24'h000000
`define CCD_HPF_DIS_RST   24'h000000
`define CCD_HPF_SHIFT     12
`define CCD_MOD_RATE_HZ   1024000
`define CCD_SMP_RATE_HZ   8000
`define CCD_DECIM         (`CCD_MOD_RATE_HZ / `CCD_SMP_RATE_HZ)
`define CCD_FIFO_DEPTH    16
`define CCD_MAX28         28'h7ffffff
`define CCD_MIN28         28'h8000000
`define CCD_MAX24         24'h7fffff
`define CCD_MIN24         24'h800000

`endif

//--- ccd_pkg.sv
// Types shared by the current channel datapath.
// Assumes ccd_defs.svh on the include path.
`include "ccd_defs.svh"
package ccd_pkg;

  typedef logic [3:0][23:0] ccd_smp_t;

  typedef enum logic [1:0] {
    CCD_IDLE = 2'b00,
    CCD_RUN  = 2'b01
  } ccd_state_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  ch;
    logic [27:0] data;
  } ccd_cur_s;

  typedef struct packed {
    logic [3:0][23:0] gain;
    logic [23:0]      hpf_dis;
    logic [3:0][23:0] wave;
    logic [3:0][39:0] dc;
    logic             rdy;
    logic             mask_rdy;
    logic             irq;
    logic [31:0]      rdata;
    ccd_state_e       st;
    logic [1:0]       ch;
    ccd_smp_t         smp;
    ccd_cur_s         cur;
    logic             hpf_off;
  } ccd_top_s;

endpackage

//--- ccd_top.sv
// Current channel datapath: input FIFO, gain, high-pass filter, waveform capture.
// Assumes samples arrive synchronous to CLK from the decimators and a synchronous register port.
`timescale 1ns/10ps
`include "ccd_defs.svh"

module ccd_fifo #(
  parameter int W = 96,
  parameter int D = 16
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic        rdy;
  } ccd_fifo_s;

  ccd_fifo_s    q_reg;
  ccd_fifo_s    q_next;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign push      = in_valid && q_reg.rdy;
  assign pop       = out_valid && out_ready;
  assign out_valid = q_reg.wp != q_reg.rp;
  assign out_data  = mem[q_reg.rp[AW-1:0]];
  assign in_ready  = q_reg.rdy;

  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.wp = q_reg.wp + 1'b1;
    end
    if (pop) begin
      q_next.rp = q_reg.rp + 1'b1;
    end
    // Registered ready keeps the source port glitch free
    q_next.rdy = (q_next.wp - q_next.rp) != DEPTH;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[q_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module ccd_top (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              SMP_VALID,
  input  wire ccd_pkg::ccd_smp_t SMP_DATA,
  output logic                   SMP_READY,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  output logic [31:0]            REG_RDATA,
  output ccd_pkg::ccd_cur_s      CUR_OUT,
  output logic                   HPF_OFF,
  output logic                   IRQ
);
  ccd_pkg::ccd_top_s  q_reg;
  ccd_pkg::ccd_top_s  q_next;
  ccd_pkg::ccd_smp_t  f_data;
  logic               f_valid;
  logic               f_ready;
  logic [3:0][31:0]   wave_ext;
  logic [3:0][31:0]   gain_ext;

  function automatic logic [27:0] sat28(input logic signed [48:0] v);
    if (v[48:27] == {22{v[48]}}) begin
      sat28 = v[27:0];
    end else begin
      sat28 = v[48] ? `CCD_MIN28 : `CCD_MAX28;
    end
  endfunction

  function automatic logic [23:0] sat24(input logic [27:0] v);
    if (v[27:23] == {5{v[27]}}) begin
      sat24 = v[23:0];
    end else begin
      sat24 = v[27] ? `CCD_MIN24 : `CCD_MAX24;
    end
  endfunction

  // Sixteen sample sets of slack while the shared multiplier is busy
  ccd_fifo #(
    .W(96),
    .D(`CCD_FIFO_DEPTH)
  ) u_fifo (
    .CLK      (CLK),
    .RST      (RST),
    .in_valid (SMP_VALID),
    .in_data  (SMP_DATA),
    .in_ready (SMP_READY),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  assign f_ready = q_reg.st == ccd_pkg::CCD_IDLE;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ext
      assign wave_ext[i] = {{8{q_reg.wave[i][23]}}, q_reg.wave[i]};
      assign gain_ext[i] = {4'h0, {4{q_reg.gain[i][23]}}, q_reg.gain[i]};
    end
  endgenerate

  always_comb begin
    logic signed [23:0] x;
    logic signed [24:0] coef;
    logic signed [48:0] prod;
    logic [27:0]        gained;
    logic [27:0]        dc_int;
    logic signed [48:0] diff;
    logic [27:0]        hp;
    logic               clr;
    x      = '0;
    coef   = '0;
    prod   = '0;
    gained = '0;
    dc_int = '0;
    diff   = '0;
    hp     = '0;
    clr    = 1'b0;
    q_next = q_reg;
    q_next.cur.valid = 1'b0;

    // Decimated words arrive once per CCD_DECIM modulator bits
    case (q_reg.st)
      ccd_pkg::CCD_IDLE: begin
        if (f_valid) begin
          q_next.smp = f_data;
          q_next.ch  = 2'h0;
          q_next.st  = ccd_pkg::CCD_RUN;
        end
      end
      ccd_pkg::CCD_RUN: begin
        // One multiplier shared by all four channels, same math for each
        x      = $signed(q_reg.smp[q_reg.ch]);
        coef   = $signed({1'b0, ~q_reg.gain[q_reg.ch][23], q_reg.gain[q_reg.ch][22:0]});
        prod   = x * coef;
        gained = sat28(prod >>> 23);
        dc_int = q_reg.dc[q_reg.ch][39:`CCD_HPF_SHIFT];
        diff   = 49'($signed(gained)) - 49'($signed(dc_int));
        hp     = q_reg.hpf_off ? gained : sat28(diff);
        q_next.dc[q_reg.ch] = q_reg.dc[q_reg.ch] + {{12{gained[27]}}, gained}
                              - {{12{dc_int[27]}}, dc_int};
        q_next.wave[q_reg.ch] = sat24(hp);
        // Stream never waits on register reads
        q_next.cur.valid = 1'b1;
        q_next.cur.ch    = q_reg.ch;
        q_next.cur.data  = hp;
        q_next.ch        = q_reg.ch + 2'h1;
        if (q_reg.ch == 2'h3) begin
          q_next.st = ccd_pkg::CCD_IDLE;
        end
      end
      default: begin
        q_next.st = ccd_pkg::CCD_IDLE;
      end
    endcase

    if (REG_WR) begin
      case (REG_ADDR)
        `CCD_OFS_GAIN_A: q_next.gain[0] = REG_WDATA[23:0];
        `CCD_OFS_GAIN_B: q_next.gain[1] = REG_WDATA[23:0];
        `CCD_OFS_GAIN_C: q_next.gain[2] = REG_WDATA[23:0];
        `CCD_OFS_GAIN_N: q_next.gain[3] = REG_WDATA[23:0];
        `CCD_OFS_HPF_DIS: q_next.hpf_dis = REG_WDATA[23:0];
        `CCD_OFS_FIRST_STATUS_REGISTER: clr = REG_WDATA[`CCD_RDY_BIT];
        `CCD_OFS_FIRST_INTERRUPT_MASK: q_next.mask_rdy = REG_WDATA[`CCD_RDY_BIT];
        default: begin
        end
      endcase
    end

    // New samples win over a clear in the same cycle
    q_next.rdy = (q_reg.rdy && !clr)
                 || (q_reg.st == ccd_pkg::CCD_RUN && q_reg.ch == 2'h3);
    q_next.irq     = q_reg.rdy && q_reg.mask_rdy;
    q_next.hpf_off = |q_reg.hpf_dis;

    if (REG_RD) begin
      case (REG_ADDR)
        `CCD_OFS_GAIN_A: q_next.rdata = gain_ext[0];
        `CCD_OFS_GAIN_B: q_next.rdata = gain_ext[1];
        `CCD_OFS_GAIN_C: q_next.rdata = gain_ext[2];
        `CCD_OFS_GAIN_N: q_next.rdata = gain_ext[3];
        `CCD_OFS_HPF_DIS: q_next.rdata = {8'h00, q_reg.hpf_dis};
        `CCD_OFS_WAVE_A: q_next.rdata = wave_ext[0];
        `CCD_OFS_WAVE_B: q_next.rdata = wave_ext[1];
        `CCD_OFS_WAVE_C: q_next.rdata = wave_ext[2];
        `CCD_OFS_WAVE_N: q_next.rdata = wave_ext[3];
        `CCD_OFS_FIRST_STATUS_REGISTER: q_next.rdata = 32'(q_reg.rdy) << `CCD_RDY_BIT;
        `CCD_OFS_FIRST_INTERRUPT_MASK: q_next.rdata = 32'(q_reg.mask_rdy) << `CCD_RDY_BIT;
        default: q_next.rdata = 32'h00000000;
      endcase
    end
  end

  // Reset clears filter disable, gains and flags to zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign REG_RDATA = q_reg.rdata;
  assign CUR_OUT   = q_reg.cur;
  assign HPF_OFF   = q_reg.hpf_off;
  assign IRQ       = q_reg.irq;
endmodule

//--- ccd_sva.sv
// Checker on the ports of ccd_top.
// Assumes one clock domain and the bind below.
`timescale 1ns/10ps
module ccd_sva (
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [7:0]        REG_ADDR,
  input wire logic [31:0]       REG_WDATA,
  input wire logic [31:0]       REG_RDATA,
  input wire ccd_pkg::ccd_cur_s CUR_OUT,
  input wire logic              HPF_OFF,
  input wire logic              IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_ch(int c);
    CUR_OUT.valid && CUR_OUT.ch == c;
  endsequence
  sequence s_dis_wr;
    REG_WR && REG_ADDR == 8'h04;
  endsequence
  property p_order;
    s_ch(0) |=> s_ch(1) ##1 s_ch(2) ##1 s_ch(3);
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
  property p_gain_fmt;
    REG_RD && REG_ADDR < 8'h04 |=> REG_RDATA[31:28] == 4'h0 && REG_RDATA[27:24] == {4{REG_RDATA[23]}};
  endproperty
  a_gain_fmt: assert property (p_gain_fmt) else $error("gain word format");
  property p_dis_fmt;
    REG_RD && REG_ADDR == 8'h04 |=> REG_RDATA[31:24] == 8'h00;
  endproperty
  a_dis_fmt: assert property (p_dis_fmt) else $error("filter word format");
  property p_wave_fmt;
    REG_RD && REG_ADDR[7:2] == 6'h02 |=> REG_RDATA[31:24] == {8{REG_RDATA[23]}};
  endproperty
  a_wave_fmt: assert property (p_wave_fmt) else $error("wave sign extension");
  property p_hpf_on;
    s_dis_wr ##0 REG_WDATA[23:0] != 24'h0 |-> ##[1:2] HPF_OFF;
  endproperty
  a_hpf_on: assert property (p_hpf_on) else $error("filters not bypassed");
  property p_hpf_off;
    s_dis_wr ##0 REG_WDATA[23:0] == 24'h0 |-> ##[1:2] !HPF_OFF;
  endproperty
  a_hpf_off: assert property (p_hpf_off) else $error("filters not active");
  property p_stat_fmt;
    REG_RD && REG_ADDR == 8'h0c |=> REG_RDATA[31:18] == 14'h0 && REG_RDATA[16:0] == 17'h0;
  endproperty
  a_stat_fmt: assert property (p_stat_fmt) else $error("status stray bits");
  property p_irq;
    $rose(IRQ) |-> $past(CUR_OUT.valid && CUR_OUT.ch == 2'd3) || $past(REG_WR, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule
bind ccd_top ccd_sva u_sva (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CUR_OUT(CUR_OUT), .HPF_OFF(HPF_OFF), .IRQ(IRQ));

//--- ccd_src.sv
// Sample source in place of the four decimators.
// Assumes the bench fills q; drives at the falling edge.
`timescale 1ns/10ps
module ccd_src (
  input  wire logic          CLK,
  input  wire logic          SMP_READY,
  input  wire logic          stall,
  output logic               SMP_VALID,
  output ccd_pkg::ccd_smp_t  SMP_DATA
);
  ccd_pkg::ccd_smp_t q[$];
  logic took = 1'b0;
  initial begin
    SMP_VALID = 1'b0;
    SMP_DATA = '0;
  end
  always @(posedge CLK) took = SMP_VALID && SMP_READY;
  // Held until taken; idle data toggles so stale words never look valid
  always @(negedge CLK) begin
    if (took) void'(q.pop_front());
    if (!SMP_VALID || took) begin
      SMP_VALID = q.size() > 0 && !stall;
      SMP_DATA = SMP_VALID ? q[0] : ~SMP_DATA;
    end
  end
endmodule

//--- current_channel_datapath_test.sv
// Self-checking bench for ccd_top with a reference model.
// Assumes ccd_src as the sample source and ccd_sva bound in.
`timescale 1ns/10ps
module current_channel_datapath_test;
  logic CLK = 1'b0, RST, REG_WR, REG_RD, stall, SMP_VALID, SMP_READY, HPF_OFF, IRQ;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, v;
  ccd_pkg::ccd_smp_t SMP_DATA, w;
  ccd_pkg::ccd_cur_s CUR_OUT;
  int errors = 0, n_compared = 0, cyc = 0, nfull = 0, rnd = 0, seed = 32'h01bc, gn[4];
  longint acc[4], expq[$];
  logic [23:0] wv[4];
  bit hoff = 0;
  logic [23:0] gt[5] = '{24'h000000, 24'h400000, 24'hc00000, 24'h7fffff, 24'h800000};
  ccd_top dut (.CLK(CLK), .RST(RST), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA), .SMP_READY(SMP_READY),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CUR_OUT(CUR_OUT), .HPF_OFF(HPF_OFF), .IRQ(IRQ));
  ccd_src src (.CLK(CLK), .SMP_READY(SMP_READY), .stall(stall), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA));
  always #20 CLK = ~CLK;
  function automatic longint sat(longint x, int b);
    longint m = longint'(1) << (b - 1);
    return x >= m ? m - 1 : (x < -m ? -m : x);
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge CLK);
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] e);
    @(negedge CLK);
    {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge CLK);
    REG_RD = 1'b0;
    chk(n, e, REG_RDATA);
  endtask
  // Model runs at push time, so gains change only while idle
  task automatic push(ccd_pkg::ccd_smp_t s);
    longint g, d, o;
    for (int c = 0; c < 4; c++) begin
      g = sat((longint'($signed(s[c])) * (8388608 + gn[c])) >>> 23, 28);
      d = acc[c] >>> 12;
      o = hoff ? g : sat(g - d, 28);
      acc[c] += g - d;
      expq.push_back(o);
      wv[c] = 24'(sat(o, 24));
    end
    src.q.push_back(s);
  endtask
  task automatic drain;
    for (int i = 0; i < 600 && expq.size() > 0; i++) @(negedge CLK);
    repeat (3) @(negedge CLK);
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
    if (!RST && CUR_OUT.valid === 1'b1) chk("cur", {4'h0, 28'(expq.pop_front())}, {4'h0, CUR_OUT.data});
  end
  always @(negedge CLK) begin
    stall <= rnd && $random(seed) % 2;
    if (!RST && SMP_READY === 1'b0) nfull++;
  end
  initial begin
    {RST, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {1'b1, 42'h0};
    acc = '{0, 0, 0, 0};
    gn = '{0, 0, 0, 0};
    repeat (16) @(negedge CLK);
    RST = 1'b0;
    rc("highpass_filter_disable", 8'h04, 32'h0);
    rc("unmapped", 8'h05, 32'h0);
    for (int i = 0; i < 4; i++) push({24'ha58ac0, 24'h5a7540, 24'ha58ac0, 24'h5a7540});
    drain;
    $display("test filter on done");
    wr(8'h04, 32'h100);
    hoff = 1;
    rc("highpass_filter_disable", 8'h04, 32'h100);
    chk("hpfoff", 32'h1, {31'h0, HPF_OFF});
    rnd = 1;
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < 4; c++) begin
        gn[c] = int'($signed(gt[(k + c) % 5]));
        wr(8'(c), {4'h0, {4{gt[(k + c) % 5][23]}}, gt[(k + c) % 5]});
        rc("gain", 8'(c), {4'h0, {4{gt[(k + c) % 5][23]}}, gt[(k + c) % 5]});
      end
      for (int i = 0; i < 4; i++) begin
        for (int c = 0; c < 4; c++) w[c] = 24'($random(seed));
        push(i == 0 ? {24'h7fffff, 24'h800000, 24'h5a7540, 24'ha58ac0} : w);
      end
      drain;
      for (int c = 0; c < 4; c++) rc("wave", 8'h08 + 8'(c), {{8{wv[c][23]}}, wv[c]});
    end
    $display("test gains done");
    rc("status", 8'h0c, 32'h20000);
    chk("irq", 32'h0, {31'h0, IRQ});
    wr(8'h0c, 32'h20000);
    rc("status", 8'h0c, 32'h0);
    wr(8'h0d, 32'h20000);
    rc("mask", 8'h0d, 32'h20000);
    wr(8'h04, 32'h0);
    hoff = 0;
    rnd = 0;
    for (int i = 0; i < 24; i++) push(w);
    drain;
    chk("full", 32'h1, {31'h0, nfull > 0});
    chk("hpfoff", 32'h0, {31'h0, HPF_OFF});
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(8'h08, 32'h0);
    rc("wave", 8'h08, {{8{wv[0][23]}}, wv[0]});
    wr(8'h0c, 32'h20000);
    repeat (2) @(negedge CLK);
    chk("irq", 32'h0, {31'h0, IRQ});
    $display("test flags done");
    end_of_test;
  end
endmodule
